// [logic/uab_core.sv]
// serial transceiver with oversampled rx, auto-baud, one-wire, line driver and infrared
//
// Local design decisions: register access over APB and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "uab_map.svh"

// Behaviour
// - double-speed mode doubles bit rate
// - sixteen or eight samples per bit
// - vote on samples 8-10 or 4-6
// - start needs two low votes else idle
// - twelve low cycles mark a break
// - sync start counts clocks for eight bits
// - wait-for-break accepts any break length in generic auto-baud
// - generic update only for valid count
// - mode code three selects constrained auto-baud
// - constrained mode needs twelve low cycles
// - sync with second fall off a quarter of the count sets error, keeps baud
// - loop-back feeds tx pin to receiver
// - open-drain only pulls low
// - open-drain makes tx pin an output only while low
// - receiver sees own transmitted frames in loop-back
// - direction output high while transmitting
// - direction rises one bit early, covers stop
// - tx pin output one clock before frame, one bit with direction
// - line driver control works with loop-back
// - infrared mode code two, pulses are low on the pins
// - infrared input from event channel
// - three infrared transmit pulse options
// - short infrared pulses decode as one
// - no double speed in infrared mode
module uab_core #(
	parameter logic [15:0] BAUD_RST = 16'h0400
) (
	// clock, reset, enable
	input  wire logic        mclk,
	input  wire logic        sys_rst,
	input  wire logic        ce,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// serial pins
	input  wire logic        rx_pin_in,
	input  wire logic        tx_pin_in,
	output logic             tx_pin_out,
	output logic             tx_pin_oe,
	output logic             driver_direction_out,
	// infrared event channel
	input  wire logic        ir_event_in
);
	import uab_pkg::*;

	// refuse a reset baud below the usable range
	if (BAUD_RST < `UAB_BAUD_MIN) begin : g_chk
		$error("BAUD_RST below minimum");
	end

	// software registers
	logic [10:0] ctrl_q;     // control fields
	logic [15:0] baud_q;     // clocks per eight bit times
	logic [15:0] ircfg_q;    // infrared widths
	logic [8:0]  rxbuf_q;    // frame error and data
	logic        rxv_q;      // receive data valid
	logic        wfb_q;      // wait_for_break
	logic        sfe_q;      // sync_field_error_flag
	// apb answer flops
	logic [31:0] prdata_q;
	logic        pready_q;
	logic        pslverr_q;
	// pin output flops
	logic        txo_q;
	logic        txoe_q;
	logic        dir_q;

	// decoded control
	uab_receive_mode_select_t receive_mode_select;
	uab_communication_mode_t  communication_mode;
	uab_irtx_t   irtx;
	logic        infrared_mode;
	logic        dbl;
	logic        generic_autobaud;
	logic        constrained_autobaud;
	logic        loopback_enable;
	logic        open_drain_enable;
	logic [1:0]  line_driver_control;
	logic [4:0]  spb;        // samples per bit
	logic [4:0]  sfirst;     // first voting sample

	assign receive_mode_select  = uab_receive_mode_select_t'(ctrl_q[`UAB_F_RECEIVE_MODE_SELECT]);
	assign communication_mode   = uab_communication_mode_t'(ctrl_q[`UAB_F_COMMUNICATION_MODE]);
	assign irtx                 = uab_irtx_t'(ctrl_q[`UAB_F_IRTX]);
	assign infrared_mode        = (communication_mode == UAB_CM_IR);
	assign generic_autobaud     = (receive_mode_select == UAB_RX_GENAB);
	assign constrained_autobaud = (receive_mode_select == UAB_RX_LINAB);
	assign loopback_enable      = ctrl_q[`UAB_F_LOOP];
	assign open_drain_enable    = ctrl_q[`UAB_F_ODRAIN];
	assign line_driver_control  = ctrl_q[`UAB_F_LDC];
	// infrared forces normal sampling
	assign dbl    = (receive_mode_select == UAB_RX_DOUBLE) && !infrared_mode;
	assign spb    = dbl ? `UAB_S_DBL : `UAB_S_NORM;
	assign sfirst = dbl ? `UAB_SF_DBL : `UAB_SF_NORM;

	// apb transfer phases
	logic acc;   // first access cycle, answer follows
	logic done;  // completing edge
	logic wr;
	logic rd;
	assign acc  = psel && penable && !pready_q;
	assign done = psel && penable && pready_q;
	assign wr   = done && pwrite;
	assign rd   = done && !pwrite;

	// tx and autobaud state needed by registers
	uab_txs_t    txs_q;
	uab_abs_t    abs_q;
	logic        ab_fin;     // measurement finished
	logic        ab_brk;     // break accepted
	logic [15:0] ab_cnt_q;
	logic        pat_ok;
	logic        rx_fin;     // frame complete
	logic [8:0]  rx_word;

	// read mux
	logic [31:0] rdata_c;
	logic        hit_c;
	always_comb
	begin
		rdata_c = 32'h0;
		hit_c   = 1'b1;
		unique case (paddr)
			`UAB_CTRL_OFS:  rdata_c = {21'h0, ctrl_q};
			`UAB_BAUD_OFS:  rdata_c = {16'h0, baud_q};
			`UAB_DATA_OFS:  rdata_c = {23'h0, rxbuf_q};
			`UAB_STAT_OFS:  rdata_c = {28'h0, sfe_q, wfb_q, (txs_q != UAB_TXS_IDLE), rxv_q};
			`UAB_IRCFG_OFS: rdata_c = {16'h0, ircfg_q};
			default:        hit_c   = 1'b0;
		endcase
	end

	// apb answer: one wait state, error on unmapped
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			pready_q  <= 1'b0;
			prdata_q  <= 32'h0;
			pslverr_q <= 1'b0;
		end
		else if (ce)
		begin
			pready_q  <= acc;
			pslverr_q <= acc && !hit_c;
			if (acc)
				prdata_q <= rdata_c;
		end
	end

	// measured count in range
	logic ab_range;
	assign ab_range = (ab_cnt_q >= `UAB_BAUD_MIN);

	// control, baud and infrared config
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			ctrl_q  <= `UAB_CTRL_RST;
			baud_q  <= BAUD_RST;
			ircfg_q <= `UAB_IRCFG_RST;
		end
		else if (ce)
		begin
			if (wr && paddr == `UAB_CTRL_OFS)
				ctrl_q <= pwdata[10:0];
			if (wr && paddr == `UAB_IRCFG_OFS)
				ircfg_q <= pwdata[15:0];
			// auto-baud result beats a software write
			if (ab_fin && ab_range && (generic_autobaud || pat_ok))
				baud_q <= ab_cnt_q;
			else if (wr && paddr == `UAB_BAUD_OFS)
				baud_q <= pwdata[15:0];
		end
	end

	// status flags, set wins over clear
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			rxv_q   <= 1'b0;
			rxbuf_q <= 9'h0;
			wfb_q   <= 1'b0;
			sfe_q   <= 1'b0;
		end
		else if (ce)
		begin
			// receive buffer, valid flag cleared by reading data
			if (rx_fin)
			begin
				rxv_q   <= 1'b1;
				rxbuf_q <= rx_word;
			end
			else if (rd && paddr == `UAB_DATA_OFS)
				rxv_q <= 1'b0;
			// wait for break: software sets, break clears
			if (wr && paddr == `UAB_STAT_OFS && pwdata[`UAB_ST_WFB])
				wfb_q <= 1'b1;
			else if (ab_brk)
				wfb_q <= 1'b0;
			// sync error: write one to clear
			if (ab_fin && constrained_autobaud && !pat_ok)
				sfe_q <= 1'b1;
			else if (wr && paddr == `UAB_STAT_OFS && pwdata[`UAB_ST_SFE])
				sfe_q <= 1'b0;
		end
	end

	// sample tick at sixteen per normal bit
	logic [8:0] div_q;
	logic [8:0] div_top;
	logic       tick_q;
	assign div_top = (baud_q[15:7] == 9'h0) ? 9'h1 : baud_q[15:7];
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			div_q  <= 9'h0;
			tick_q <= 1'b0;
		end
		else if (ce)
		begin
			// same tick rate, half the samples when doubled
			if (div_q >= div_top - 9'h1)
			begin
				div_q  <= 9'h0;
				tick_q <= 1'b1;
			end
			else
			begin
				div_q  <= div_q + 9'h1;
				tick_q <= 1'b0;
			end
		end
	end

	// pin input synchronisers: bit 0 rx pin, bit 1 tx pin
	logic [1:0] pin_raw;
	logic [1:0] pin_f;
	assign pin_raw = {tx_pin_in, rx_pin_in};
	for (genvar g = 0; g < 2; g++)
	begin : g_sync
		logic [2:0] s_q;  // shift chain
		logic       f_q;  // accepted level
		always_ff @(posedge mclk)
		begin
			if (sys_rst)
			begin
				s_q <= 3'h7;
				f_q <= 1'b1;
			end
			else if (ce)
			begin
				s_q <= {s_q[1:0], pin_raw[g]};
				if (s_q[1] == s_q[2])
					f_q <= s_q[2];
			end
		end
		assign pin_f[g] = f_q;
	end

	// receiver source: tx pin in loop-back, else rx pin
	logic raw_line;
	logic ir_pulse;
	logic rx_line;
	assign raw_line = loopback_enable ? pin_f[1] : pin_f[0];
	// pin low is a pulse; event channel bypasses the pin
	assign ir_pulse = ctrl_q[`UAB_F_IREVT] ? ir_event_in : !raw_line;

	// infrared decoder: qualified pulse holds a zero one bit time
	logic [7:0]  ir_lo_q;
	logic [12:0] ir_hold_q;
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			ir_lo_q   <= 8'h0;
			ir_hold_q <= 13'h0;
		end
		else if (ce)
		begin
			if (!ir_pulse)
				ir_lo_q <= 8'h0;
			else if (ir_lo_q != 8'hff)
				ir_lo_q <= ir_lo_q + 8'h1;
			// short pulses never load the hold
			if (ir_pulse && ({1'b0, ir_lo_q} + 9'h1 >= {1'b0, ircfg_q[`UAB_F_IRRXMIN]}))
				ir_hold_q <= baud_q[15:3];
			else if (ir_hold_q != 13'h0)
				ir_hold_q <= ir_hold_q - 13'h1;
		end
	end
	assign rx_line = infrared_mode ? (ir_hold_q == 13'h0) : raw_line;

	// autobaud busy blocks the frame receiver
	logic ab_en;
	logic ab_busy;
	assign ab_en   = generic_autobaud || constrained_autobaud;
	assign ab_busy = ab_en && (abs_q != UAB_ABS_BRK);

	// frame receiver, stepped by sample ticks
	uab_rxs_t   rxs_q;
	logic [4:0] rx_sc_q;   // sample number in bit
	logic [1:0] vote_q;
	logic [2:0] rx_bit_q;
	logic [7:0] rx_sh_q;
	logic [4:0] rx_n;
	logic       maj;
	assign rx_n    = rx_sc_q + 5'h1;
	assign maj     = (vote_q[1] & vote_q[0]) | (vote_q[1] & rx_line) | (vote_q[0] & rx_line);
	assign rx_fin  = tick_q && (rxs_q == UAB_RXS_STOP) && (rx_n == sfirst + 5'h2);
	assign rx_word = {!maj, rx_sh_q};
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			rxs_q    <= UAB_RXS_IDLE;
			rx_sc_q  <= 5'h0;
			vote_q   <= 2'h0;
			rx_bit_q <= 3'h0;
			rx_sh_q  <= 8'h0;
		end
		else if (ce && tick_q)
		begin
			if (rxs_q == UAB_RXS_IDLE)
			begin
				// first low sample is sample one
				if (!rx_line && !ab_busy)
				begin
					rxs_q   <= UAB_RXS_START;
					rx_sc_q <= 5'h1;
				end
			end
			else
			begin
				rx_sc_q <= (rx_n == spb) ? 5'h0 : rx_n;
				if (rx_n >= sfirst && rx_n < sfirst + 5'h2)
					vote_q <= {vote_q[0], rx_line};
				if (rx_n == sfirst + 5'h2)
				begin
					unique case (rxs_q)
						UAB_RXS_START:
						begin
							if (maj)
								rxs_q <= UAB_RXS_IDLE;
						end
						UAB_RXS_DATA:
							rx_sh_q <= {maj, rx_sh_q[7:1]};
						UAB_RXS_STOP:
							rxs_q <= UAB_RXS_IDLE; // later stop bits ignored
						default:
							rxs_q <= UAB_RXS_IDLE;
					endcase
				end
				else if (rx_n == spb)
				begin
					// bit boundary
					if (rxs_q == UAB_RXS_START)
					begin
						rxs_q    <= UAB_RXS_DATA;
						rx_bit_q <= 3'h0;
					end
					else if (rxs_q == UAB_RXS_DATA)
					begin
						if (rx_bit_q == 3'h7)
							rxs_q <= UAB_RXS_STOP;
						rx_bit_q <= rx_bit_q + 3'h1;
					end
				end
			end
		end
	end

	// auto-baud: break, gap, sync start, measure
	logic [3:0]  lowcnt_q;
	logic [2:0]  edges_q;
	logic [15:0] e2_q;
	logic        lv_q;
	logic        fall;
	logic [17:0] lim_lo;
	logic [17:0] lim_hi;
	logic [17:0] e2x4;
	assign fall   = lv_q && !rx_line;
	assign ab_brk = ab_en && (abs_q == UAB_ABS_BRK) && !rx_line
		&& ((lowcnt_q >= `UAB_BREAK_CYC - 4'h1)
		|| (generic_autobaud && wfb_q));
	assign ab_fin = (abs_q == UAB_ABS_MEAS) && fall && (edges_q == `UAB_SYNC_LAST - 3'h1);
	// second falling edge sits near a quarter of the count
	assign e2x4   = {e2_q, 2'b00};
	assign lim_lo = {2'b00, ab_cnt_q} - {4'h0, ab_cnt_q[15:2]};
	assign lim_hi = {2'b00, ab_cnt_q} + {4'h0, ab_cnt_q[15:2]};
	assign pat_ok = (e2x4 >= lim_lo) && (e2x4 <= lim_hi);
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			abs_q    <= UAB_ABS_BRK;
			lowcnt_q <= 4'h0;
			edges_q  <= 3'h0;
			e2_q     <= 16'h0;
			ab_cnt_q <= 16'h0;
			lv_q     <= 1'b1;
		end
		else if (ce)
		begin
			lv_q <= rx_line;
			// consecutive low clocks, saturating
			if (rx_line)
				lowcnt_q <= 4'h0;
			else if (lowcnt_q != `UAB_BREAK_CYC)
				lowcnt_q <= lowcnt_q + 4'h1;
			if (!ab_en)
				abs_q <= UAB_ABS_BRK;
			else
			begin
				unique case (abs_q)
					UAB_ABS_BRK:
						if (ab_brk)
							abs_q <= UAB_ABS_GAP;
					UAB_ABS_GAP:
						if (rx_line)
							abs_q <= UAB_ABS_SYNC;
					UAB_ABS_SYNC:
						if (!rx_line)
						begin
							// sync start bit starts the count
							abs_q    <= UAB_ABS_MEAS;
							ab_cnt_q <= 16'h1;
							edges_q  <= 3'h0;
						end
					UAB_ABS_MEAS:
					begin
						if (ab_cnt_q != 16'hffff)
							ab_cnt_q <= ab_cnt_q + 16'h1;
						else
							abs_q <= UAB_ABS_BRK; // stuck line, abandon
						if (fall)
						begin
							edges_q <= edges_q + 3'h1;
							if (edges_q == `UAB_SYNC_E2 - 3'h1)
								e2_q <= ab_cnt_q;
							if (edges_q == `UAB_SYNC_LAST - 3'h1)
								abs_q <= UAB_ABS_BRK; // eighth bit time reached
						end
					end
				endcase
			end
		end
	end

	// transmitter: guard, then start, eight data, stop
	logic [9:0] tx_sh_q;
	logic [3:0] tx_bit_q;
	logic [4:0] tx_sc_q;
	logic [7:0] tx_clk_q;   // clocks into the bit
	logic [4:0] tx_n;
	assign tx_n = tx_sc_q + 5'h1;
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			txs_q    <= UAB_TXS_IDLE;
			tx_sh_q  <= 10'h3ff;
			tx_bit_q <= 4'h0;
			tx_sc_q  <= 5'h0;
			tx_clk_q <= 8'h0;
		end
		else if (ce)
		begin
			if (tx_clk_q != 8'hff)
				tx_clk_q <= tx_clk_q + 8'h1;
			unique case (txs_q)
				UAB_TXS_IDLE:
					if (wr && paddr == `UAB_DATA_OFS)
					begin
						txs_q   <= UAB_TXS_GUARD;
						tx_sh_q <= {1'b1, pwdata[7:0], 1'b0};
						tx_sc_q <= 5'h0;
					end
				UAB_TXS_GUARD:
				begin
					// one bit of guard with direction, else one clock
					if (!line_driver_control[0] || (tick_q && tx_n == spb))
					begin
						txs_q    <= UAB_TXS_FRAME;
						tx_sc_q  <= 5'h0;
						tx_bit_q <= 4'h0;
						tx_clk_q <= 8'h0;
					end
					else if (tick_q)
						tx_sc_q <= tx_n;
				end
				UAB_TXS_FRAME:
					if (tick_q)
					begin
						if (tx_n == spb)
						begin
							tx_sc_q  <= 5'h0;
							tx_clk_q <= 8'h0;
							tx_bit_q <= tx_bit_q + 4'h1;
							tx_sh_q  <= {1'b1, tx_sh_q[9:1]};
							if (tx_bit_q == 4'h9)
								txs_q <= UAB_TXS_IDLE;
						end
						else
							tx_sc_q <= tx_n;
					end
				default:
					txs_q <= UAB_TXS_IDLE;
			endcase
		end
	end

	// line level with infrared pulse shaping
	logic in_frame;
	logic bitval;
	logic pulse;
	logic lvl;
	assign in_frame = (txs_q == UAB_TXS_FRAME);
	assign bitval   = in_frame ? tx_sh_q[0] : 1'b1;
	always_comb
	begin
		pulse = 1'b0;
		if (in_frame && !bitval)
		begin
			unique case (irtx)
				UAB_IRT_316:   pulse = (tx_sc_q < `UAB_IR_316);
				UAB_IRT_FIXED: pulse = (tx_clk_q < ircfg_q[`UAB_F_IRTXW]);
				default:       pulse = 1'b1;
			endcase
		end
	end
	assign lvl = infrared_mode ? !pulse : bitval;

	// registered pin drive and driver direction
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			txo_q  <= 1'b1;
			txoe_q <= 1'b1;
			dir_q  <= 1'b0;
		end
		else if (ce)
		begin
			txo_q  <= open_drain_enable ? 1'b0 : lvl;
			if (open_drain_enable)
				txoe_q <= !lvl;
			else if (line_driver_control[1])
				txoe_q <= (txs_q != UAB_TXS_IDLE);
			else
				txoe_q <= 1'b1;
			dir_q  <= line_driver_control[0] && (txs_q != UAB_TXS_IDLE);
		end
	end

	// outputs straight from flops
	assign prdata               = prdata_q;
	assign pready               = pready_q;
	assign pslverr              = pslverr_q;
	assign tx_pin_out           = txo_q;
	assign tx_pin_oe            = txoe_q;
	assign driver_direction_out = dir_q;
endmodule : uab_core
`default_nettype wire

// [logic/uab_map.svh]
// register map, field positions, reset values and timing counts
`ifndef UAB_MAP_SVH
`define UAB_MAP_SVH
// register byte offsets
`define UAB_CTRL_OFS   12'h000
`define UAB_BAUD_OFS   12'h004
`define UAB_DATA_OFS   12'h008
`define UAB_STAT_OFS   12'h00c
`define UAB_IRCFG_OFS  12'h010
// control fields
`define UAB_F_RECEIVE_MODE_SELECT   1:0
`define UAB_F_COMMUNICATION_MODE    3:2
`define UAB_F_LOOP     4
`define UAB_F_ODRAIN   5
`define UAB_F_LDC      7:6
`define UAB_F_IREVT    8
`define UAB_F_IRTX     10:9
// infrared config fields
`define UAB_F_IRTXW    7:0
`define UAB_F_IRRXMIN  15:8
// status bits
`define UAB_ST_RXV     0
`define UAB_ST_TXB     1
`define UAB_ST_WFB     2
`define UAB_ST_SFE     3
// reset values
`define UAB_CTRL_RST   11'h000
`define UAB_IRCFG_RST  16'h0404
// timing counts
`define UAB_BREAK_CYC  4'hc
`define UAB_BAUD_MIN   16'h0064
`define UAB_S_NORM     5'h10
`define UAB_S_DBL      5'h08
`define UAB_SF_NORM    5'h08
`define UAB_SF_DBL     5'h04
`define UAB_IR_316     5'h03
`define UAB_SYNC_E2    3'h1
`define UAB_SYNC_LAST  3'h4
`endif

// [logic/uab_pkg.sv]
// types shared by the serial transceiver extensions
`default_nettype none
package uab_pkg;
	// receive mode codes
	typedef enum logic [1:0] {
		UAB_RX_NORMAL = 2'h0,
		UAB_RX_DOUBLE = 2'h1,
		UAB_RX_GENAB  = 2'h2,
		UAB_RX_LINAB  = 2'h3
	} uab_receive_mode_select_t;
	// communication mode codes
	typedef enum logic [1:0] {
		UAB_CM_ASYNC = 2'h0,
		UAB_CM_RSV1  = 2'h1,
		UAB_CM_IR    = 2'h2,
		UAB_CM_RSV3  = 2'h3
	} uab_communication_mode_t;
	// infrared transmit pulse options
	typedef enum logic [1:0] {
		UAB_IRT_316   = 2'h0,
		UAB_IRT_FIXED = 2'h1,
		UAB_IRT_OFF   = 2'h2,
		UAB_IRT_RSV   = 2'h3
	} uab_irtx_t;
	// state machines
	typedef enum logic [1:0] {UAB_RXS_IDLE, UAB_RXS_START, UAB_RXS_DATA, UAB_RXS_STOP} uab_rxs_t;
	typedef enum logic [1:0] {UAB_TXS_IDLE, UAB_TXS_GUARD, UAB_TXS_FRAME} uab_txs_t;
	typedef enum logic [1:0] {UAB_ABS_BRK, UAB_ABS_GAP, UAB_ABS_SYNC, UAB_ABS_MEAS} uab_abs_t;
endpackage : uab_pkg
`default_nettype wire

// [test/uab_core_properties.sv]
// checker on the serial transceiver top ports
`timescale 1ns/100ps
`default_nettype none
`include "uab_map.svh"
module uab_core_properties (
	// clock, reset, enable
	input wire logic        mclk,
	input wire logic        sys_rst,
	input wire logic        ce,
	// apb
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// pins
	input wire logic        tx_pin_out,
	input wire logic        tx_pin_oe,
	input wire logic        driver_direction_out
);
	logic [10:0] ctl_q; // mirror of the control word
	logic        nrm;   // push-pull plain async line
	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);
	// follow control writes at their completing edge
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
			ctl_q <= '0;
		else if (ce && psel && penable && pready && pwrite && paddr == `UAB_CTRL_OFS)
			ctl_q <= pwdata[10:0];
	end
	assign nrm = !ctl_q[5] && ctl_q[3:2] != 2'h2;
	a_apb_wait: assert property (psel && penable && !pready |=> pready)
		else $error("apb answer not after one wait state");
	a_pready_one: assert property (pready |=> !pready)
		else $error("pready held too long");
	a_err_unmapped: assert property (pready && paddr > `UAB_IRCFG_OFS |-> pslverr && prdata == '0)
		else $error("unmapped access not refused");
	a_od_low: assert property (ctl_q[5] && $past(ctl_q[5]) && tx_pin_oe |-> !tx_pin_out)
		else $error("open drain drove the line high");
	a_dir_off: assert property (!ctl_q[6] && !$past(ctl_q[6]) |-> !driver_direction_out)
		else $error("direction high while disabled");
	a_dir_lead: assert property ($rose(driver_direction_out) && nrm |-> tx_pin_out [*8])
		else $error("data before guard time");
	a_dir_stop: assert property ($fell(driver_direction_out) && nrm |-> $past(tx_pin_out))
		else $error("direction fell before stop bit end");
	a_oe_frame: assert property (ctl_q[7:6] == 2'h3 && $stable(ctl_q) && nrm
		|-> tx_pin_oe == driver_direction_out)
		else $error("pin enable not tied to frame");
	// main scenarios reached
	c_dir_frame: cover property ($fell(driver_direction_out));
	c_refused: cover property (pready && pslverr);
	c_od_pull: cover property (ctl_q[5] && tx_pin_oe);
endmodule : uab_core_properties
bind uab_core uab_core_properties i_uab_core_properties (.mclk, .sys_rst, .ce, .psel, .penable,
	.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .tx_pin_out, .tx_pin_oe,
	.driver_direction_out);
`default_nettype wire

// [test/uab_core_tb_top.sv]
// self-checking bench for the serial transceiver extensions
`timescale 1ns/100ps
`default_nettype none
`include "uab_map.svh"
module uab_core_tb_top;
	import uab_pkg::*;
	logic        mclk    = 1'b0; // 10 mhz clock
	logic        sys_rst = 1'b1; // sync reset
	logic        ce      = 1'b1; // clock enable
	logic        psel;           // apb request, idled at time zero
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata, rd;     // read data, last taken
	logic        pready, pslverr, er, tx_pin_out, tx_pin_oe, dir, rx_line, ir_evt, line_lvl;
	logic        mon_clr = 1'b0; // clears pin monitors
	int          fail_count, cmp_count, dir_n, oe_n, run_n, first_w;
	always #50 mclk = ~mclk;
	uab_core #(.BAUD_RST(16'h0100)) i_uab_core (.mclk, .sys_rst, .ce, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .rx_pin_in(rx_line),
		.tx_pin_in(line_lvl), .tx_pin_out, .tx_pin_oe, .driver_direction_out(dir),
		.ir_event_in(ir_evt));
	uab_node i_uab_node (.mclk, .tx_pin_out, .tx_pin_oe, .rx_line, .ir_evt, .line_lvl);
	// pin monitors: direction and enable time, first low pulse
	always @(posedge mclk)
	begin
		if (mon_clr)
		begin
			dir_n = 0;
			oe_n = 0;
			run_n = 0;
			first_w = 0;
		end
		else
		begin
			dir_n += dir;
			oe_n += tx_pin_oe;
			if (!tx_pin_out)
				run_n++;
			else if (run_n != 0 && first_w == 0)
				first_w = run_n;
		end
	end
	// apb transfer held until pready
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge mclk);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do
			@(posedge mclk);
		while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// exact compare
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e)
		begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	// range compare
	task chk_in(input string nm, input logic [31:0] lo, input logic [31:0] hi,
		input logic [31:0] g);
		cmp_count++;
		if ((g >= lo && g <= hi) !== 1'b1)
		begin
			fail_count++;
			$display("[ERR] %s expected %h..%h seen %h", nm, lo, hi, g);
		end
	endtask : chk_in
	task rdchk(input string nm, input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, '0);
		chk(nm, e, rd);
	endtask : rdchk
	// poll a status bit, bounded
	task wait_st(input int b, input logic v);
		int n;
		n = 0;
		do
		begin
			apb(1'b0, `UAB_STAT_OFS, '0);
			n++;
		end
		while (rd[b] !== v && n < 200);
		chk("status poll", v, rd[b]);
	endtask : wait_st
	task rx_get(input logic [31:0] e);
		wait_st(0, 1'b1);
		rdchk("rx data", `UAB_DATA_OFS, e);
	endtask : rx_get
	task clr;
		mon_clr <= 1'b1;
		@(posedge mclk);
		mon_clr <= 1'b0;
	endtask : clr
	task stop_test;
		$display("compares %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : stop_test
	// watchdog well beyond the planned run
	initial
	begin
		repeat (60000) @(posedge mclk);
		fail_count++;
		stop_test();
	end
	// test sequence
	initial
	begin
		{psel, penable, pwrite, paddr, pwdata} <= '0;
		repeat (12) @(posedge mclk);
		sys_rst <= 1'b0;
		rdchk("ctrl", `UAB_CTRL_OFS, 32'h0);
		rdchk("baud", `UAB_BAUD_OFS, 32'h100);
		rdchk("ircfg", `UAB_IRCFG_OFS, 32'h404);
		rdchk("status", `UAB_STAT_OFS, 32'h0);
		rdchk("unmapped", 12'h014, 32'h0);
		chk("slverr", 1, er);
		$display("test reset done");
		i_uab_node.send(8'ha5, 32, 1'b0, 10'h0);
		rx_get(32'ha5);
		i_uab_node.brk(4);
		repeat (400) @(posedge mclk);
		rdchk("glitch", `UAB_STAT_OFS, 32'h0);
		apb(1'b1, `UAB_CTRL_OFS, 32'h1);
		i_uab_node.send(8'h3c, 16, 1'b0, 10'h0);
		rx_get(32'h3c);
		$display("test receive done");
		// loop-back with line driver, far node talking on the rx pin
		apb(1'b1, `UAB_CTRL_OFS, 32'hd0);
		clr();
		fork
			i_uab_node.send(8'h00, 32, 1'b0, 10'h0);
			begin
				apb(1'b1, `UAB_DATA_OFS, 32'h96);
				// freeze mid-frame: pins hold for 40 extra cycles
				repeat (100) @(posedge mclk);
				ce <= 1'b0;
				repeat (40) @(posedge mclk);
				ce <= 1'b1;
			end
		join
		rx_get(32'h96);
		wait_st(1, 1'b0);
		chk_in("dir time", 390, 392, dir_n);
		chk_in("oe time", 390, 392, oe_n);
		apb(1'b1, `UAB_CTRL_OFS, 32'h30);
		apb(1'b1, `UAB_DATA_OFS, 32'h5a);
		rx_get(32'h5a);
		wait_st(1, 1'b0);
		$display("test one-wire done");
		// generic auto-baud: too short a sync is ignored
		apb(1'b1, `UAB_CTRL_OFS, 32'h2);
		i_uab_node.brk(20);
		i_uab_node.send(8'h55, 8, 1'b0, 10'h0);
		rdchk("baud kept", `UAB_BAUD_OFS, 32'h100);
		apb(1'b1, `UAB_STAT_OFS, 32'h4);
		i_uab_node.brk(6);
		i_uab_node.send(8'h55, 14, 1'b0, 10'h0);
		apb(1'b0, `UAB_BAUD_OFS, '0);
		chk_in("baud new", 111, 113, rd);
		// constrained auto-baud: good sync, then a wrong one
		// a sync's last low bit outlasts 12 clocks and re-arms; leave the mode to reset it
		apb(1'b1, `UAB_CTRL_OFS, 32'h0);
		apb(1'b1, `UAB_CTRL_OFS, 32'h3);
		i_uab_node.brk(20);
		i_uab_node.send(8'h55, 16, 1'b0, 10'h0);
		apb(1'b0, `UAB_BAUD_OFS, '0);
		chk_in("baud lin", 127, 129, rd);
		apb(1'b1, `UAB_CTRL_OFS, 32'h0);
		apb(1'b1, `UAB_CTRL_OFS, 32'h3);
		i_uab_node.brk(20);
		i_uab_node.send(8'h54, 16, 1'b0, 10'h0);
		i_uab_node.send(8'hff, 16, 1'b0, 10'h0);
		apb(1'b0, `UAB_STAT_OFS, '0);
		chk("sync err", 1, rd[3]);
		apb(1'b0, `UAB_BAUD_OFS, '0);
		chk_in("baud held", 127, 129, rd);
		$display("test auto-baud done");
		// infrared transmit pulse options, 16 clock bits
		for (int o = 0; o < 3; o++)
		begin
			apb(1'b1, `UAB_CTRL_OFS, 32'h8 | (o << 9));
			clr();
			apb(1'b1, `UAB_DATA_OFS, 32'h55);
			wait_st(1, 1'b0);
			chk("ir pulse", (o == 0) ? 3 : (o == 1) ? 4 : 16, first_w);
		end
		// infrared receive from events, double speed asked for
		apb(1'b0, `UAB_DATA_OFS, '0);
		apb(1'b1, `UAB_CTRL_OFS, 32'h109);
		i_uab_node.send(8'h00, 16, 1'b1, 10'h1e0);
		rx_get(32'hf0);
		$display("test infrared done");
		stop_test();
	end
endmodule : uab_core_tb_top
`default_nettype wire

// [test/uab_node.sv]
// remote serial node on the rx pin, event channel and shared line
`timescale 1ns/100ps
`default_nettype none
module uab_node (
	// clock
	input  wire logic mclk,
	// device pins
	input  wire logic tx_pin_out,
	input  wire logic tx_pin_oe,
	output var  logic rx_line,
	output var  logic ir_evt,
	output logic      line_lvl
);
	// pull-up holds the shared line high when released
	assign line_lvl = tx_pin_oe ? tx_pin_out : 1'b1;
	// idle line high, no pulse
	initial
	begin
		rx_line = 1'b1;
		ir_evt  = 1'b0;
	end
	// line low for n clocks, then idle gap
	task brk(input int n);
		rx_line <= 1'b0;
		repeat (n) @(posedge mclk);
		rx_line <= 1'b1;
		repeat (20) @(posedge mclk);
	endtask : brk
	// 8n1 frame lsb first; ir mode pulses the event for zeros, sm marks short pulses
	task send(input logic [7:0] b, input int t, input logic ir, input logic [9:0] sm);
		logic [9:0] f;
		int         w;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++)
		begin
			w = sm[i] ? 2 : 6;
			rx_line <= ir ? 1'b0 : f[i];
			ir_evt  <= ir && !f[i];
			repeat (ir ? w : t) @(posedge mclk);
			if (ir)
				ir_evt <= 1'b0;
			repeat (ir ? t - w : 0) @(posedge mclk);
		end
	endtask : send
endmodule : uab_node
`default_nettype wire
